// *** test/rsr_host_model.sv ***
// Host controller model: register master and busy poller
`timescale 1ns/10ps
`default_nettype none
module rsr_host_model
  import rsr_pkg::*;
(
  input wire logic i_core_clk, // Clock
  input wire logic [DATA_W-1:0] i_rdata, // Read data
  output logic [ADDR_W-1:0] o_addr, // Address
  output logic [DATA_W-1:0] o_wdata, // Write data
  output logic o_wr, // Write strobe
  output logic o_rd // Read strobe
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    @(posedge i_core_clk);
    d = i_rdata;
  endtask
  // Bounded, so a stuck busy cannot hang the host
  task automatic poll(output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int n = 0; n < 64 && !ok; n++) begin
      rd(OFF_CHAN_EVT, d);
      ok = (d[BUSY_BIT] === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// *** test/rsr_status_report_assertions.sv ***
// Port checker of the status and mode report block
`timescale 1ns/10ps
`default_nettype none
module rsr_status_report_assertions
  import rsr_pkg::*;
(
  input wire logic i_core_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic [ADDR_W-1:0] i_addr, // Address
  input wire logic [DATA_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [DATA_W-1:0] o_rdata, // Read data
  input wire logic [ACT_N-1:0] i_activity, // Jobs
  input wire logic [EV_N-1:0] i_event, // Causes
  input wire logic i_cca_done, // CCA done
  input wire logic i_cca_busy, // Not clear
  input wire logic i_probe_hit, // Probe hit
  input wire logic [CH_W-1:0] i_channel, // Channel
  input wire logic [3:0] i_sys_state, // State
  input wire logic i_sys_state_vld, // State valid
  input wire logic o_busy, // Busy
  input wire logic o_rx_mode, // Receive
  input wire logic o_idle_mode, // Idle
  input wire logic o_probe_en // Probe
);
  logic rd_st;
  logic quiet;
  assign rd_st = i_rd && i_addr == OFF_CHAN_EVT;
  assign quiet = !(i_cca_done || i_probe_hit);
  function automatic logic [2:0] top_ev(input logic [7:0] e);
    top_ev = 3'h0;
    for (int k = 0; k < 8; k++) if (e[k]) top_ev = k[2:0];
  endfunction
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // Busy, causes and channel
  a_busy_set: assert property (
    |i_activity |=> o_busy) else $error("busy missing");
  a_busy_low: assert property (
    !(|i_activity) |=> !o_busy) else $error("busy stuck");
  a_cause_code: assert property (
    i_event != 0 ##1 i_event == 0 && !i_rd ##1 rd_st && i_event == 0
    |=> o_rdata[3:1] == top_ev($past(i_event, 3))) else $error("bad cause");
  a_read_clr: assert property (
    rd_st && quiet && i_event == 0 ##1 (quiet && i_event == 0) [*2]
    ##1 rd_st && i_event == 0 |=> o_rdata[3:0] == {3'h0, $past(o_busy)})
    else $error("flags kept");
  a_not_clear: assert property (
    i_cca_done && i_cca_busy ##1 !i_rd ##1 rd_st |=> o_rdata[0])
    else $error("not clear lost");
  a_chan_load: assert property (
    (i_cca_done ^ i_probe_hit) ##1 quiet && !i_wr ##1 rd_st && quiet
    |=> o_rdata[7:4] == $past(i_channel, 3)) else $error("bad channel");
  // ==========================================================
  // Modes and state
  a_rx_cmd: assert property (
    i_wr && i_addr == OFF_COMMAND && i_wdata == CMD_RECEIVE
    |=> o_rx_mode && !o_idle_mode) else $error("no receive");
  a_idle_cmd: assert property (
    i_wr && i_addr == OFF_COMMAND && i_wdata == CMD_IDLE
    |=> o_idle_mode && !o_rx_mode) else $error("no idle");
  a_probe_off: assert property (
    !o_idle_mode |-> !o_probe_en) else $error("probe outside idle");
  a_sys_state: assert property (
    i_rd && i_addr == OFF_OP_STATE && i_sys_state_vld
    |=> o_rdata == {4'h0, $past(i_sys_state)}) else $error("bad state");
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == ZERO_BYTE) else $error("stray read data");
endmodule
bind rsr_status_report rsr_status_report_assertions u_chk (.i_core_clk,
  .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_activity,
  .i_event, .i_cca_done, .i_cca_busy, .i_probe_hit, .i_channel,
  .i_sys_state, .i_sys_state_vld, .o_busy, .o_rx_mode, .o_idle_mode,
  .o_probe_en);
`default_nettype wire

// *** test/rsr_status_report_tb.sv ***
// Self-checking bench of the status and mode report block
`timescale 1ns/10ps
`default_nettype none
module rsr_status_report_tb;
  import rsr_pkg::*;
  logic clk, rst, cdone, cbusy, phit, svld, wr, rd, busy, rxm, idm, pen, ok;
  logic fch;
  logic [7:0] addr, wdata, rdata, ev, d;
  logic [5:0] act;
  logic [3:0] ch, sst;
  logic [3:0] st [7] = '{ST_UNDETERMINED, ST_STARTUP, ST_ROM_COPY,
    ST_CAL_LNA, ST_CAL_PLL, ST_CAL_RC, ST_CAL_KICK};
  int failures, comparisons, seed, k;
  rsr_status_report dut (.i_core_clk(clk), .i_reset(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_activity(act), .i_event(ev), .i_cca_done(cdone), .i_cca_busy(cbusy),
    .i_probe_hit(phit), .i_channel(ch), .i_force_channel(fch),
    .i_sys_state(sst), .i_sys_state_vld(svld), .o_busy(busy),
    .o_rx_mode(rxm), .o_idle_mode(idm), .o_probe_en(pen));
  rsr_host_model host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  function automatic logic [2:0] top(input logic [7:0] e);
    top = 3'h0;
    for (int i = 0; i < 8; i++) if (e[i]) top = i[2:0];
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk8(d, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    seed = 32'h24021f56;
    {rst, cdone, cbusy, phit, svld, fch, act, ev, ch, sst} = {1'b1, 27'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(OFF_CHAN_EVT, ZERO_BYTE);
    rc(OFF_IDLE_CFG, IDLE_CFG_RST);
    rc(OFF_OP_STATE, {4'h0, ST_STANDBY});
    rc(8'h55, ZERO_BYTE);
    for (k = 0; k < ACT_N; k++) begin
      @(posedge clk);
      act <= 6'h1 << k;
      settle(2 + ($random(seed) & 7));
      chk1(busy, 1'b1);
      rc(OFF_CHAN_EVT, 8'h01);
      act <= 6'h0;
      host.poll(ok);
      chk1(ok, 1'b1);
      chk1(busy, 1'b0);
    end
    for (k = 0; k < 9; k++) begin
      @(posedge clk);
      ev <= (k < 8) ? 8'h1 << k : 8'($random(seed));
      @(posedge clk);
      ev <= 8'h0;
      rc(OFF_CHAN_EVT, {4'h0, top(ev), 1'b0});
      rc(OFF_CHAN_EVT, ZERO_BYTE);
    end
    @(posedge clk);
    ch <= 4'($random(seed));
    {cdone, cbusy} <= 2'b11;
    @(posedge clk);
    cdone <= 1'b0;
    rc(OFF_CHAN_EVT, {ch, 4'h1});
    rc(OFF_CHAN_EVT, {ch, 4'h0});
    ch <= ~ch;
    phit <= 1'b1;
    @(posedge clk);
    phit <= 1'b0;
    rc(OFF_CHAN_EVT, {ch, 4'h0});
    // A channel write only counts while forcing is on
    host.wr(OFF_CHAN_EVT, {~ch, 4'h0});
    rc(OFF_CHAN_EVT, {ch, 4'h0});
    fch <= 1'b1;
    host.wr(OFF_CHAN_EVT, {~ch, 4'h0});
    rc(OFF_CHAN_EVT, {~ch, 4'h0});
    fch <= 1'b0;
    host.wr(OFF_IDLE_CFG, 8'h01);
    rc(OFF_IDLE_CFG, 8'h01);
    host.wr(OFF_COMMAND, CMD_RECEIVE);
    settle(0);
    chk1(rxm, 1'b1);
    rc(OFF_OP_STATE, {4'h0, ST_RX});
    host.wr(OFF_COMMAND, CMD_IDLE);
    settle(2);
    chk1(idm, 1'b1);
    chk1(pen, 1'b1);
    host.wr(OFF_OP_STATE, 8'hFF);
    rc(OFF_OP_STATE, {4'h0, ST_IDLE});
    host.wr(OFF_COMMAND, CMD_RECEIVE);
    settle(2);
    chk1(pen, 1'b0);
    @(posedge clk);
    svld <= 1'b1;
    foreach (st[i]) begin
      sst <= st[i];
      rc(OFF_OP_STATE, {4'h0, st[i]});
    end
    final_report();
  end
endmodule
`default_nettype wire

// *** verilog/rsr_event_latch.sv ***
// Sticky clear-on-read event latch for the channel and event status register
`timescale 1ns/10ps
`default_nettype none
module rsr_event_latch
  import rsr_pkg::*;
(
  input wire logic i_core_clk, // System clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [EV_N-1:0] i_event, // Event pulses
  input wire logic i_cca_done, // CCA transmission finished
  input wire logic i_cca_busy, // Channel found not clear
  input wire logic i_probe_hit, // Probe found energy or packet
  input wire logic [CH_W-1:0] i_channel, // Channel in use
  input wire logic i_chan_wr, // Host forces channel field
  input wire logic [CH_W-1:0] i_chan_wdata, // Forced channel
  input wire logic i_clear, // Host read of the register
  output logic [CAUSE_W-1:0] o_cause, // Latched interrupt cause
  output logic o_not_clear, // Latched channel busy flag
  output logic [CH_W-1:0] o_channel // Latched channel index
);
  logic [CAUSE_W-1:0] cause_d, cause_q;
  logic not_clear_d, not_clear_q;
  logic [CH_W-1:0] chan_d, chan_q;

  function automatic logic [CAUSE_W-1:0] encode_cause(
    input logic [EV_N-1:0] ev
  );
    logic [CAUSE_W-1:0] c;
    c = CAUSE_LOW_BATT;
    for (int k = 0; k < EV_N; k++) begin
      if (ev[k]) begin
        c = CAUSE_W'(k);
      end
    end
    return c;
  endfunction

  // A new event in the read cycle survives: set wins over clear
  always_comb begin
    cause_d = i_clear ? CAUSE_LOW_BATT : cause_q;
    not_clear_d = i_clear ? 1'b0 : not_clear_q;
    chan_d = chan_q;
    if (|i_event) begin
      cause_d = encode_cause(i_event);
    end
    if (i_cca_done) begin
      chan_d = i_channel;
      if (i_cca_busy) begin
        not_clear_d = 1'b1;
      end
    end
    if (i_probe_hit) begin
      chan_d = i_channel;
    end
    if (i_chan_wr) begin
      chan_d = i_chan_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cause_q <= CAUSE_LOW_BATT;
      not_clear_q <= 1'b0;
      chan_q <= '0;
    end else begin
      cause_q <= cause_d;
      not_clear_q <= not_clear_d;
      chan_q <= chan_d;
    end
  end

  assign o_cause = cause_q;
  assign o_not_clear = not_clear_q;
  assign o_channel = chan_q;
endmodule
`default_nettype wire

// *** verilog/rsr_pkg.sv ***
// Package: register map, field layout and codes of the status/mode report
package rsr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_CHAN_EVT = 8'h02;
  localparam logic [7:0] OFF_IDLE_CFG = 8'h10;
  localparam logic [7:0] OFF_OP_STATE = 8'h3C;
  // Command codes
  localparam logic [7:0] CMD_RECEIVE = 8'h01;
  localparam logic [7:0] CMD_IDLE = 8'h03;
  // Field positions of the channel and event status register and of the idle configuration register
  localparam int CH_LSB = 4;
  localparam int CH_W = 4;
  localparam int CAUSE_LSB = 1;
  localparam int CAUSE_W = 3;
  localparam int BUSY_BIT = 0;
  localparam int PROBE_EN_BIT = 0;
  localparam logic [7:0] IDLE_CFG_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Interrupt cause codes
  localparam logic [2:0] CAUSE_CRC_FAIL = 3'h7;
  localparam logic [2:0] CAUSE_DWELL_TO = 3'h6;
  localparam logic [2:0] CAUSE_CCA_FAIL = 3'h5;
  localparam logic [2:0] CAUSE_TX_DONE = 3'h4;
  localparam logic [2:0] CAUSE_TX_BUF = 3'h3;
  localparam logic [2:0] CAUSE_RX_DATA = 3'h2;
  localparam logic [2:0] CAUSE_HOUSEKEEP = 3'h1;
  localparam logic [2:0] CAUSE_LOW_BATT = 3'h0;
  // Event request vector, index order sets priority (highest index wins)
  localparam int EV_LOW_BATT = 0;
  localparam int EV_HOUSEKEEP = 1;
  localparam int EV_RX_DATA = 2;
  localparam int EV_TX_BUF = 3;
  localparam int EV_TX_DONE = 4;
  localparam int EV_CCA_FAIL = 5;
  localparam int EV_DWELL_TO = 6;
  localparam int EV_CRC_FAIL = 7;
  localparam int EV_N = 8;
  // Operating state codes; the last six are chosen values
  localparam logic [3:0] ST_UNDETERMINED = 4'hF;
  localparam logic [3:0] ST_STARTUP = 4'hB;
  localparam logic [3:0] ST_ROM_COPY = 4'hA;
  localparam logic [3:0] ST_CAL_LNA = 4'h9;
  localparam logic [3:0] ST_CAL_PLL = 4'h8;
  localparam logic [3:0] ST_CAL_RC = 4'h7;
  localparam logic [3:0] ST_CAL_KICK = 4'h6;
  localparam logic [3:0] ST_NV_READ = 4'h5;
  localparam logic [3:0] ST_NV_WRITE = 4'h4;
  localparam logic [3:0] ST_IDLE = 4'h3;
  localparam logic [3:0] ST_TX = 4'h2;
  localparam logic [3:0] ST_RX = 4'h1;
  localparam logic [3:0] ST_STANDBY = 4'h0;
  localparam int ST_W = 4;
  // Activity inputs: each bit tags one busy-causing job
  localparam int ACT_CAL = 0;
  localparam int ACT_NV = 1;
  localparam int ACT_RX_PKT = 2;
  localparam int ACT_TX_BUF = 3;
  localparam int ACT_HOUSEKEEP = 4;
  localparam int ACT_BURST = 5;
  localparam int ACT_N = 6;
  // Mode controller states, Gray coded along standby-idle-rx
  typedef enum logic [1:0] {
    RSR_STANDBY = 2'b00,
    RSR_IDLE = 2'b01,
    RSR_RX = 2'b11
  } rsr_mode_e;
endpackage

// *** verilog/rsr_status_report.sv ***
// Status and mode report register bank of the radio transceiver
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rsr_status_report
  import rsr_pkg::*;
(
  input wire logic i_core_clk, // System clock, 200 MHz
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] i_addr, // Register address
  input wire logic [DATA_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [DATA_W-1:0] o_rdata, // Read data, one cycle after i_rd
  input wire logic [ACT_N-1:0] i_activity, // Busy-causing jobs running
  input wire logic [EV_N-1:0] i_event, // Interrupt cause pulses
  input wire logic i_cca_done, // CCA transmission finished pulse
  input wire logic i_cca_busy, // Channel not clear, with cca_done
  input wire logic i_probe_hit, // Probe energy or packet pulse
  input wire logic [CH_W-1:0] i_channel, // Channel in use
  input wire logic i_force_channel, // Force channel mode enabled
  input wire logic [3:0] i_sys_state, // Internal state when not moded
  input wire logic i_sys_state_vld, // Internal state overrides mode
  output logic o_busy, // Busy flag
  output logic o_rx_mode, // Receiver mode active
  output logic o_idle_mode, // Idle mode active
  output logic o_probe_en // Periodic energy probe wakeups
);
  // ===========================================================
  // Register bank
  // ===========================================================
  logic [DATA_W-1:0] rdata_d, rdata_q;
  logic [DATA_W-1:0] idle_cfg_d, idle_cfg_q;
  logic busy_d, busy_q;
  logic probe_d, probe_q;
  logic rx_d, rx_q;
  logic idle_d, idle_q;
  rsr_mode_e mode_d, mode_q;
  logic [CAUSE_W-1:0] cause;
  logic not_clear;
  logic [CH_W-1:0] chan;
  logic rd_status, chan_wr;

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    return a == off;
  endfunction

  // Clearing only on a read keeps a write of the channel harmless
  assign rd_status = i_rd && hit(i_addr, OFF_CHAN_EVT);
  assign chan_wr = i_wr && hit(i_addr, OFF_CHAN_EVT) && i_force_channel;

  rsr_event_latch u_evt (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_event(i_event),
    .i_cca_done(i_cca_done),
    .i_cca_busy(i_cca_busy),
    .i_probe_hit(i_probe_hit),
    .i_channel(i_channel),
    .i_chan_wr(chan_wr),
    .i_chan_wdata(i_wdata[CH_LSB +: CH_W]),
    .i_clear(rd_status),
    .o_cause(cause),
    .o_not_clear(not_clear),
    .o_channel(chan)
  );

  // ===========================================================
  // Mode control
  // ===========================================================
  always_comb begin
    mode_d = mode_q;
    idle_cfg_d = idle_cfg_q;
    if (i_wr && hit(i_addr, OFF_COMMAND)) begin
      if (i_wdata == CMD_RECEIVE) begin
        mode_d = RSR_RX;
      end else if (i_wdata == CMD_IDLE) begin
        mode_d = RSR_IDLE;
      end
    end
    if (i_wr && hit(i_addr, OFF_IDLE_CFG)) begin
      idle_cfg_d = i_wdata;
    end
    // Mode pins are registered decodes, so no gate follows the flop
    rx_d = (mode_d == RSR_RX);
    idle_d = (mode_d == RSR_IDLE);
    // Probe only runs while idle; enabling it elsewhere waits
    probe_d = idle_d && idle_cfg_d[PROBE_EN_BIT];
    // Busy follows activity with one register stage
    busy_d = |i_activity;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mode_q <= RSR_STANDBY;
      idle_cfg_q <= IDLE_CFG_RST;
      probe_q <= 1'b0;
      rx_q <= 1'b0;
      idle_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      idle_cfg_q <= idle_cfg_d;
      probe_q <= probe_d;
      rx_q <= rx_d;
      idle_q <= idle_d;
      busy_q <= busy_d;
    end
  end

  // ===========================================================
  // Read path
  // ===========================================================
  function automatic logic [3:0] state_code(
    input rsr_mode_e m,
    input logic vld,
    input logic [3:0] sys
  );
    logic [3:0] s;
    s = ST_STANDBY;
    if (vld) begin
      s = sys;
    end else begin
      unique case (m)
        RSR_STANDBY: begin
          s = ST_STANDBY;
        end
        RSR_IDLE: begin
          s = ST_IDLE;
        end
        RSR_RX: begin
          s = ST_RX;
        end
        default: begin
          s = ST_UNDETERMINED;
        end
      endcase
    end
    return s;
  endfunction

  always_comb begin
    rdata_d = ZERO_BYTE;
    if (i_rd) begin
      unique case (i_addr)
        OFF_CHAN_EVT: begin
          rdata_d[CH_LSB +: CH_W] = chan;
          rdata_d[CAUSE_LSB +: CAUSE_W] = cause;
          // Busy is shared with the not-clear flag on bit 0
          rdata_d[BUSY_BIT] = busy_q | not_clear;
        end
        OFF_IDLE_CFG: begin
          rdata_d = idle_cfg_q;
        end
        OFF_OP_STATE: begin
          rdata_d[ST_W-1:0] = state_code(mode_q, i_sys_state_vld, i_sys_state);
        end
        default: begin
          rdata_d = ZERO_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdata_q <= ZERO_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_busy = busy_q;
  assign o_rx_mode = rx_q;
  assign o_idle_mode = idle_q;
  assign o_probe_en = probe_q;
endmodule
`default_nettype wire
